// *** logic/qlm_pkg.sv ***
`default_nettype none
package qlm_pkg;
  // channel count
  localparam int NCH = 4;
  // system clock rate in MHz
  localparam int CLK_MHZ = 125;
  // wake-up filter, least 15 us
  localparam int WU_FILT_US = 15;
  localparam int WU_FILT_CYC = WU_FILT_US * CLK_MHZ;
  // mode-select debounce, least 2 us
  localparam int MODE_DEB_US = 2;
  localparam int MODE_DEB_CYC = MODE_DEB_US * CLK_MHZ;
  // stuck-dominant timeout, 25 ms (inside 25..50 ms)
  localparam int RX_TO_MS = 25;
  localparam int RX_TO_CYC = RX_TO_MS * CLK_MHZ * 1000;
  // standby-to-sleep delay, typ 350 ms (inside 100..500 ms)
  localparam int STBY_MS = 350;
  localparam int STBY_CYC = STBY_MS * CLK_MHZ * 1000;
  // register byte offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_WAKE_SRC = 4'h8;
  localparam logic [3:0] REG_BUS_LVL = 4'hc;
  // control register fields
  localparam int CTRL_WAKE_EN_LSB = 0;
  localparam logic [3:0] CTRL_WAKE_EN_RST = 4'hf;
  // status register field positions
  localparam int ST_FSM_LSB = 0;
  localparam int ST_MODE_LSB = 3;
  localparam int ST_INH_BIT = 5;
  localparam int ST_HOT_BIT = 6;
  localparam int ST_UV_BIT = 7;
  localparam int ST_TO_LSB = 8;
  localparam int ST_HOLD_LSB = 12;
  localparam int ST_PU_LSB = 16;
  // operating modes, first select pin in bit 0
  localparam logic [1:0] MODE_SLEEP = 2'h0;
  localparam logic [1:0] MODE_HIGH_SPEED = 2'h1;
  localparam logic [1:0] MODE_LOW_SPEED = 2'h2;
  localparam logic [1:0] MODE_NORMAL = 2'h3;
  // controller states, one-hot
  typedef enum logic [2:0] {
    ST_STBY = 3'h1,
    ST_SLEEP = 3'h2,
    ST_ACT = 3'h4
  } qlm_fsm_t;
  // fault inputs travel together
  typedef struct packed {
    logic uv;
    logic hot;
  } qlm_flt_t;
endpackage
`default_nettype wire

// *** logic/qlm_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module qlm_top
  import qlm_pkg::*;
#(
  parameter int RX_TO_C = RX_TO_CYC,
  parameter int STBY_C = STBY_CYC
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  // host pins
  input wire logic [NCH-1:0] i_tx_in,
  input wire logic i_mode_sel_first,
  input wire logic i_mode_sel_second,
  output logic [NCH-1:0] o_rx_out,
  output logic [NCH-1:0] o_rx_out_oe,
  // bus lines
  input wire logic [NCH-1:0] i_bus_line,
  output logic [NCH-1:0] o_bus_line,
  output logic [NCH-1:0] o_bus_line_oe,
  output logic [NCH-1:0] o_pullup_en,
  output logic [1:0] o_slew_mode,
  // supply and protection
  output logic o_regulator_inhibit_out,
  output logic o_regulator_inhibit_out_oe,
  output logic o_mode_pulldown_en,
  input wire logic i_thermal_hot,
  input wire logic i_undervoltage,
  // avalon-mm slave
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest
);
  localparam int WUW = $clog2(WU_FILT_CYC);
  localparam int DBW = $clog2(MODE_DEB_CYC);
  localparam int TOW = $clog2(RX_TO_C);
  localparam int SBW = $clog2(STBY_C);

  // whole module state
  typedef struct packed {
    logic [NCH-1:0] tx_m, tx_s;      // transmit input sync
    logic [1:0] mode_m, mode_s;      // mode select sync
    logic [NCH-1:0] bus_m, bus_s;    // bus level sync
    qlm_flt_t flt_m, flt_s;          // fault input sync
    logic [1:0] mode_stab;           // debounced mode
    logic [DBW-1:0] deb_cnt;         // debounce counter
    qlm_fsm_t fsm;                   // controller state
    logic [SBW-1:0] stby_cnt;        // standby timer
    logic [NCH-1:0] wu_ref;          // last accepted level
    logic [NCH-1:0][WUW-1:0] wu_cnt; // wake filters
    logic [NCH-1:0][TOW-1:0] to_cnt; // dominant timers
    logic [NCH-1:0] to_flag;         // timeout latched
    logic [NCH-1:0] bus_prev;        // for edge detect
    logic [NCH-1:0] hold;            // interrupt hold low
    logic [NCH-1:0] wake_src;        // sticky wake sources
    logic [NCH-1:0] wake_en;         // wake enable mask
    logic [NCH-1:0] bus_oe, bus_lvl; // line drivers
    logic [NCH-1:0] rx_oe, rx_lvl;   // receive outputs
    logic [NCH-1:0] pu_en;           // master pull-ups
    logic regulator_inhibit_out;                       // inhibit driven
    logic [1:0] slew;                // slew setting
    logic pd_en;                     // mode pull-downs
    logic av_wait;                   // waitrequest
    logic [31:0] av_rdata;           // read data
  } qlm_st_t;

  qlm_st_t q, nx;
  logic rst_meta, rst_n;
  logic mode_act;
  logic [NCH-1:0] wake_ev;
  logic av_req;

  // counter end test, shared by all timers
  function automatic logic at_end(input int cnt, input int lim);
    at_end = (cnt == lim - 1);
  endfunction

  // reset release through two flops
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  assign mode_act = |q.mode_stab;
  assign av_req = i_avs_read | i_avs_write;

  // next-state logic
  always_comb begin
    nx = q;
    wake_ev = '0;
    // pins pass two flops before use
    nx.tx_m = i_tx_in;
    nx.tx_s = q.tx_m;
    nx.mode_m = {i_mode_sel_second, i_mode_sel_first};
    nx.mode_s = q.mode_m;
    nx.bus_m = i_bus_line;
    nx.bus_s = q.bus_m;
    nx.flt_m = '{uv: i_undervoltage, hot: i_thermal_hot};
    nx.flt_s = q.flt_m;
    nx.bus_prev = q.bus_s;
    // mode debounce; glitches shorter than window ignored
    if (q.mode_s != q.mode_stab) begin
      if (at_end(int'(q.deb_cnt), MODE_DEB_CYC)) begin
        nx.mode_stab = q.mode_s;
        nx.deb_cnt = '0;
      end else begin
        nx.deb_cnt = q.deb_cnt + 1'b1;
      end
    end else begin
      nx.deb_cnt = '0;
    end
    // per-channel wake filter and dominant timer
    for (int i = 0; i < NCH; i++) begin
      if (!mode_act && q.bus_s[i] != q.wu_ref[i]) begin
        // either edge direction counts
        if (at_end(int'(q.wu_cnt[i]), WU_FILT_CYC)) begin
          wake_ev[i] = q.wake_en[i];
          nx.wu_ref[i] = q.bus_s[i];
          nx.wu_cnt[i] = '0;
        end else begin
          nx.wu_cnt[i] = q.wu_cnt[i] + 1'b1;
        end
      end else begin
        // active mode keeps reference tracking the line
        nx.wu_ref[i] = q.bus_s[i];
        nx.wu_cnt[i] = '0;
      end
      if (q.bus_s[i] && !q.bus_prev[i]) begin
        nx.to_flag[i] = 1'b0;
        nx.to_cnt[i] = '0;
      end else if (q.fsm == ST_ACT && !q.bus_s[i] && !q.to_flag[i]) begin
        if (at_end(int'(q.to_cnt[i]), RX_TO_C)) begin
          nx.to_flag[i] = 1'b1;
        end else begin
          nx.to_cnt[i] = q.to_cnt[i] + 1'b1;
        end
      end else if (q.fsm != ST_ACT) begin
        nx.to_cnt[i] = '0;
      end
    end
    // wake source hold; mode select releases it
    if (mode_act) begin
      nx.hold = '0;
    end else begin
      nx.hold = q.hold | wake_ev;
    end
    // controller
    unique case (q.fsm)
      ST_STBY: begin
        if (mode_act) begin
          nx.fsm = ST_ACT;
        end else if (|wake_ev) begin
          nx.stby_cnt = '0;
        end else if (at_end(int'(q.stby_cnt), STBY_C)) begin
          nx.fsm = ST_SLEEP;
          nx.stby_cnt = '0;
        end else begin
          nx.stby_cnt = q.stby_cnt + 1'b1;
        end
      end
      ST_SLEEP: begin
        if (mode_act) begin
          nx.fsm = ST_ACT;
        end else if (|wake_ev) begin
          nx.fsm = ST_STBY;
          nx.stby_cnt = '0;
        end
      end
      ST_ACT: begin
        // host chose sleep: inhibit stays until delay ends
        if (!mode_act) begin
          nx.fsm = ST_STBY;
          nx.stby_cnt = '0;
        end
      end
      default: begin
        nx.fsm = ST_STBY;
      end
    endcase
    // line drivers only in active mode, never in sleep setting
    // pin values come from the second sync stage only; the first
    // stage may still be settling, so outputs pay one extra edge
    // of latency rather than risk a metastable value reaching them
    for (int i = 0; i < NCH; i++) begin
      nx.bus_oe[i] = nx.fsm == ST_ACT && nx.mode_stab != MODE_SLEEP
        && !q.tx_s[i] && !q.flt_s.hot && !q.flt_s.uv;
      if (q.flt_s.hot) begin
        nx.rx_oe[i] = 1'b1;
      end else if (nx.fsm == ST_ACT) begin
        nx.rx_oe[i] = !q.bus_s[i];
      end else begin
        nx.rx_oe[i] = nx.hold[i];
      end
      nx.pu_en[i] = !q.flt_s.hot && !nx.to_flag[i];
    end
    nx.bus_lvl = ~nx.bus_oe;
    nx.rx_lvl = ~nx.rx_oe;
    nx.regulator_inhibit_out = nx.fsm != ST_SLEEP;
    // slew setting follows mode; high speed drives fall only
    unique case (nx.mode_stab)
      MODE_HIGH_SPEED: nx.slew = MODE_HIGH_SPEED;
      MODE_LOW_SPEED: nx.slew = MODE_LOW_SPEED;
      MODE_NORMAL: nx.slew = MODE_NORMAL;
      default: nx.slew = MODE_SLEEP;
    endcase
    nx.pd_en = 1'b1;
    // sticky wake sources, set beats clear
    nx.wake_src = q.wake_src | wake_ev;
    // bus slave: one wait cycle, then complete
    nx.av_wait = 1'b1;
    if (av_req && q.av_wait) begin
      nx.av_wait = 1'b0;
      nx.av_rdata = '0;
      unique case (i_avs_address)
        REG_CTRL: nx.av_rdata[CTRL_WAKE_EN_LSB +: NCH] = q.wake_en;
        REG_STATUS: begin
          nx.av_rdata[ST_FSM_LSB +: 3] = q.fsm;
          nx.av_rdata[ST_MODE_LSB +: 2] = q.mode_stab;
          nx.av_rdata[ST_INH_BIT] = q.regulator_inhibit_out;
          nx.av_rdata[ST_HOT_BIT] = q.flt_s.hot;
          nx.av_rdata[ST_UV_BIT] = q.flt_s.uv;
          nx.av_rdata[ST_TO_LSB +: NCH] = q.to_flag;
          nx.av_rdata[ST_HOLD_LSB +: NCH] = q.hold;
          nx.av_rdata[ST_PU_LSB +: NCH] = q.pu_en;
        end
        REG_WAKE_SRC: nx.av_rdata[NCH-1:0] = q.wake_src;
        REG_BUS_LVL: nx.av_rdata[NCH-1:0] = q.bus_s;
        default: nx.av_rdata = '0;
      endcase
    end else if (av_req && !q.av_wait && i_avs_write) begin
      // write lands at completing edge
      if (i_avs_address == REG_CTRL) begin
        nx.wake_en = i_avs_writedata[CTRL_WAKE_EN_LSB +: NCH];
      end else if (i_avs_address == REG_WAKE_SRC) begin
        nx.wake_src = (q.wake_src & ~i_avs_writedata[NCH-1:0]) | wake_ev;
      end
    end
  end

  // state register; power-on floats the line drivers and drives rx enables, pull-ups, inhibit and waitrequest high
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.tx_m <= '1;
      q.tx_s <= '1;
      q.bus_m <= '1;
      q.bus_s <= '1;
      q.bus_prev <= '1;
      q.wu_ref <= '1;
      q.fsm <= ST_STBY;
      q.hold <= '1;
      q.wake_en <= CTRL_WAKE_EN_RST;
      q.bus_lvl <= '1;
      q.rx_oe <= '1;
      q.pu_en <= '1;
      q.regulator_inhibit_out <= 1'b1;
      q.pd_en <= 1'b1;
      q.av_wait <= 1'b1;
    end else begin
      q <= nx;
    end
  end

  assign o_rx_out = q.rx_lvl;
  assign o_rx_out_oe = q.rx_oe;
  assign o_bus_line = q.bus_lvl;
  assign o_bus_line_oe = q.bus_oe;
  assign o_pullup_en = q.pu_en;
  assign o_slew_mode = q.slew;
  assign o_regulator_inhibit_out = q.regulator_inhibit_out;
  assign o_regulator_inhibit_out_oe = q.regulator_inhibit_out;
  assign o_mode_pulldown_en = q.pd_en;
  assign o_avs_readdata = q.av_rdata;
  assign o_avs_waitrequest = q.av_wait;

  // checks
  a_sleep_no_drive: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    (q.mode_stab == MODE_SLEEP) |-> (q.bus_oe == '0))
    else $error("line driven in sleep setting");
  // outputs lag the second sync stage by one edge
  a_tx_high_rec: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    (q.bus_oe & $past(q.tx_s)) == '0)
    else $error("line driven with transmit input high");
  a_rx_mirror: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    (q.fsm == ST_ACT && !$past(q.flt_s.hot)) |-> (q.rx_oe == ~$past(q.bus_s)))
    else $error("receive output not mirroring bus");
  a_rx_hold_src: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    (q.fsm != ST_ACT && !$past(q.flt_s.hot)) |-> (q.rx_oe == q.hold))
    else $error("receive output not showing hold");
  a_to_pullup: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    $rose(q.to_flag[1]) |-> !q.pu_en[1] && $past(q.to_cnt[1]) == TOW'(RX_TO_C - 1))
    else $error("timeout without full count or pull-up kept");
  a_to_clear: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    (q.bus_s[0] && !q.bus_prev[0] && !q.flt_s.hot) |=> (!q.to_flag[0] && q.pu_en[0]))
    else $error("rising edge did not clear timeout");
  a_stby_sleep: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    (q.fsm == ST_STBY && q.stby_cnt == SBW'(STBY_C - 1) && !mode_act && wake_ev == '0)
    |=> (q.fsm == ST_SLEEP && !q.regulator_inhibit_out))
    else $error("standby did not end in sleep");
  a_act_inh: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    (q.fsm == ST_SLEEP && mode_act) |=> (q.fsm == ST_ACT && q.regulator_inhibit_out))
    else $error("mode select did not enter active");
  // protection acts one edge after the synced flag
  a_hot_cut: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    $past(q.flt_s.hot) |-> (q.bus_oe == '0 && q.pu_en == '0 && q.rx_oe == '1))
    else $error("overtemperature not cutting paths");
  a_uv_off: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    $past(q.flt_s.uv) |-> (q.bus_oe == '0))
    else $error("transmitter on in undervoltage");
  // slew code always follows the debounced mode
  a_slew_mode: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    q.slew == q.mode_stab)
    else $error("slew setting not following mode");
  // accepted wake marks its channel for the host
  a_wake_hold: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    (wake_ev != '0) |=> ((q.hold & $past(wake_ev)) == $past(wake_ev)))
    else $error("wake source not held low");
  // wake from sleep goes to standby with inhibit driven
  a_wake_stby: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    (q.fsm == ST_SLEEP && !mode_act && wake_ev != '0) |=> (q.fsm == ST_STBY && q.regulator_inhibit_out))
    else $error("wake did not restart standby");
  // active state never keeps a wake hold
  a_act_no_hold: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    (q.fsm == ST_ACT) |-> (q.hold == '0))
    else $error("hold left set in active state");
  // host sleep keeps inhibit through a fresh standby delay
  a_host_sleep: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    (q.fsm == ST_ACT && !mode_act) |=> (q.fsm == ST_STBY && q.regulator_inhibit_out && q.stby_cnt == '0))
    else $error("host sleep did not start standby delay");
  // debounced mode moves only after a full window
  a_deb_window: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    (q.mode_stab != $past(q.mode_stab)) |-> ($past(q.deb_cnt) == DBW'(MODE_DEB_CYC - 1)))
    else $error("mode taken before debounce window");
  // wake on channel 2 only after the full filter time
  a_wake_filt: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    $rose(q.wake_src[2]) |-> ($past(q.wu_cnt[2]) == WUW'(WU_FILT_CYC - 1)))
    else $error("wake taken before filter time");
endmodule
`default_nettype wire

// *** tb/qlm_bus_node.sv ***
`timescale 1ns/1ns
`default_nettype none
// far-side slave nodes on the four single-wire lines
module qlm_bus_node
  import qlm_pkg::*;
(
  // device side
  input wire logic [NCH-1:0] i_drive_oe,
  // slave nodes pulling dominant
  input wire logic [NCH-1:0] i_slave_dom,
  // resolved line levels
  output logic [NCH-1:0] o_level
);
  // wired-and line, released lines float high on the termination
  assign o_level = ~(i_drive_oe | i_slave_dom);
endmodule
`default_nettype wire

// *** tb/qlm_top_test.sv ***
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin fails++; \
  $display("mismatch %s exp %h got %h", nm, ex, got); end end
module qlm_top_test
  import qlm_pkg::*;
;
  // clock, reset and pins
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [NCH-1:0] tx = 4'hf;
  logic ms_a = 1'b0;
  logic ms_b = 1'b0;
  logic hot = 1'b0;
  logic uv = 1'b0;
  logic [NCH-1:0] slave_dom = 4'h0;
  logic [NCH-1:0] lvl;
  logic [NCH-1:0] rx, rx_oe, bus_d, bus_oe, pu;
  logic [1:0] slew;
  logic regulator_inhibit_out, inh_oe, pd_en;
  // avalon master signals
  logic [3:0] addr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic wait_rq;
  logic [31:0] d;
  int fails = 0;
  int n_checks = 0;
  // 125 mhz
  always #4 clk = ~clk;
  // small counts keep the run short
  qlm_top #(.RX_TO_C(50), .STBY_C(200)) i_qlm_top (
    .i_clk_sys(clk), .i_resetn(rst_n), .i_tx_in(tx), .i_mode_sel_first(ms_a),
    .i_mode_sel_second(ms_b), .o_rx_out(rx), .o_rx_out_oe(rx_oe), .i_bus_line(lvl),
    .o_bus_line(bus_d), .o_bus_line_oe(bus_oe), .o_pullup_en(pu), .o_slew_mode(slew),
    .o_regulator_inhibit_out(regulator_inhibit_out), .o_regulator_inhibit_out_oe(inh_oe),
    .o_mode_pulldown_en(pd_en), .i_thermal_hot(hot), .i_undervoltage(uv),
    .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wait_rq));
  qlm_bus_node i_qlm_bus_node (.i_drive_oe(bus_oe), .i_slave_dom(slave_dom), .o_level(lvl));
  // verdict and end of run
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // one transfer, held until waitrequest is sampled low
  task automatic avs(input logic w, input logic [3:0] a, input logic [31:0] v,
                     output logic [31:0] q);
    int k;
    @(posedge clk);
    rd <= ~w;
    wr <= w;
    addr <= a;
    wdata <= v;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (wait_rq !== 1'b0 && k < 50);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (k >= 50) begin
      fails++;
      close_out();
    end
  endtask
  // mode pins, then wait out sync and debounce
  task automatic set_mode(input logic [1:0] m);
    @(posedge clk);
    ms_a <= m[0];
    ms_b <= m[1];
    repeat (300) @(posedge clk);
  endtask
  // bounded wait for the inhibit driver to float
  task automatic wait_inh_off();
    int k;
    k = 0;
    while (inh_oe !== 1'b0 && k < 2000) begin
      @(posedge clk);
      k++;
    end
    if (k >= 2000) begin
      fails++;
      close_out();
    end
  endtask
  // main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    // power-on standby state
    `CHK("rx_oe por", 4'hf, rx_oe)
    `CHK("inh_oe por", 1'b1, inh_oe)
    `CHK("pulldown", 1'b1, pd_en)
    `CHK("inh lvl", 1'b1, regulator_inhibit_out)
    `CHK("slew por", MODE_SLEEP, slew)
    avs(1'b0, REG_CTRL, 32'h0, d);
    `CHK("ctrl rst", 32'hf, d)
    avs(1'b1, REG_CTRL, 32'h5, d);
    avs(1'b0, REG_CTRL, 32'h0, d);
    `CHK("ctrl wr", 32'h5, d)
    avs(1'b1, REG_CTRL, 32'hf, d);
    avs(1'b1, 4'h2, 32'hffff_ffff, d);
    avs(1'b0, 4'h2, 32'h0, d);
    `CHK("unmapped", 32'h0, d)
    avs(1'b0, REG_STATUS, 32'h0, d);
    `CHK("fsm stby", 3'h1, d[2:0])
    // no mode change: standby runs out into sleep
    wait_inh_off();
    avs(1'b0, REG_STATUS, 32'h0, d);
    `CHK("fsm sleep", 3'h2, d[2:0])
    // sleep ignores the transmit pins
    tx <= 4'h0;
    repeat (10) @(posedge clk);
    `CHK("sleep tx", 4'h0, bus_oe)
    tx <= 4'hf;
    // remote wake on channel 2, falling edge
    slave_dom <= 4'h4;
    repeat (1950) @(posedge clk);
    `CHK("inh wake", 1'b1, inh_oe)
    `CHK("rx hold", 1'b1, rx_oe[2])
    avs(1'b0, REG_WAKE_SRC, 32'h0, d);
    `CHK("wake src", 4'h4, d[3:0])
    avs(1'b1, REG_WAKE_SRC, 32'h4, d);
    avs(1'b0, REG_WAKE_SRC, 32'h0, d);
    `CHK("wake clr", 4'h0, d[3:0])
    // released short: rising edge wakes too
    slave_dom <= 4'h0;
    repeat (1950) @(posedge clk);
    avs(1'b0, REG_WAKE_SRC, 32'h0, d);
    `CHK("wake rise", 4'h4, d[3:0])
    // each active mode: slew code, transmit and receive paths
    for (int m = 1; m < 4; m++) begin
      set_mode(m[1:0]);
      `CHK("slew", m[1:0], slew)
      `CHK("rx rel", 4'h0, rx_oe)
      avs(1'b0, REG_STATUS, 32'h0, d);
      `CHK("fsm act", 3'h4, d[2:0])
      `CHK("inh act", 1'b1, inh_oe)
      tx <= 4'he;
      repeat (8) @(posedge clk);
      `CHK("tx dom", 4'h1, bus_oe)
      `CHK("tx pin", 4'he, bus_d)
      `CHK("rx dom", 4'h1, rx_oe)
      `CHK("rx pin", 4'he, rx)
      tx <= 4'hf;
      repeat (8) @(posedge clk);
      `CHK("tx rec", 4'h0, bus_oe)
      `CHK("rx rec", 4'h0, rx_oe)
    end
    // stuck dominant on channel 1 only
    slave_dom <= 4'h2;
    repeat (70) @(posedge clk);
    `CHK("pu off", 4'hd, pu)
    avs(1'b0, REG_STATUS, 32'h0, d);
    `CHK("to flag", 4'h2, d[11:8])
    slave_dom <= 4'h0;
    repeat (8) @(posedge clk);
    `CHK("pu back", 4'hf, pu)
    // overtemperature with transmit requested
    tx <= 4'h0;
    hot <= 1'b1;
    repeat (8) @(posedge clk);
    `CHK("hot tx", 4'h0, bus_oe)
    `CHK("hot pu", 4'h0, pu)
    `CHK("hot rx", 4'hf, rx_oe)
    hot <= 1'b0;
    repeat (8) @(posedge clk);
    `CHK("cool tx", 4'hf, bus_oe)
    // undervoltage cuts transmitters
    uv <= 1'b1;
    repeat (8) @(posedge clk);
    `CHK("uv tx", 4'h0, bus_oe)
    avs(1'b0, REG_STATUS, 32'h0, d);
    `CHK("uv bit", 1'b1, d[ST_UV_BIT])
    uv <= 1'b0;
    tx <= 4'hf;
    // host selects sleep: inhibit held, then floats
    set_mode(MODE_SLEEP);
    `CHK("inh hold", 1'b1, inh_oe)
    wait_inh_off();
    // remote wake on channel 1 after active use: only it is held low
    slave_dom <= 4'h2;
    repeat (1950) @(posedge clk);
    `CHK("rx src", 4'h2, rx_oe)
    `CHK("rx src pin", 4'hd, rx)
    `CHK("inh rewake", 1'b1, inh_oe)
    close_out();
  end
endmodule
`default_nettype wire
